// >>> logic/adc_seq_regs.vh
// Constants for the dual-slope converter sequencer and display driver.
// Assumes inclusion by the sequencer module only; definitions only.
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH
// Phase codes
`define PH_NULL      2'h0
`define PH_INTEG     2'h1
`define PH_DEINT     2'h2
// Timing counts
`define PRESCALE     2'h3
`define INTEG_COUNTS 12'h3e8
`define FULL_SCALE   12'h7d0
`define CYCLE_COUNTS 12'hfa0
`define BP_HALF      9'h18f
`endif

// >>> logic/adc_seq.v
// Sequencer, reading counter and seven-segment driver for a 3.5-digit converter.
// Assumes an analog front end driving comparator levels from another domain.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_regs.vh"

// Functional notes
// - Cycle runs offset-null, integrate, deintegrate, then repeats forever.
// - Offset-null shorts sense inputs to midpoint, charges reference, closes offset loop.
// - Integrate opens loop, connects sense pins, integrates difference fixed time.
// - Sign latched at end of integrate, used for deintegrate and polarity.
// - Deintegrate ties low input to midpoint, opposite reference, counts to zero.
// - Displayed reading is the deintegrate count, 1000 times input over reference.
// - LCD backplane is a square wave at clock divided by 800.
// - LCD segments in phase with backplane when off, inverted when on.
// - Segment check high forces all segments on, showing minus 1888.
// - In LCD segment check the segments hold constant level, no toggling.
// - Overload blanks three low digits, leaving only the leading indication.
// - LED variant has no backplane; segments are static active-low sinks.
// - Hold input reads low when open, so display updates by default.
// - Oscillator clock divided by four forms the count clock.
// - Integrate 1000, deintegrate 0 to 2000, null remainder; 4000 counts total.
// - Hold high keeps converting but freezes display latches until low.
// - Polarity segment on for negative inputs, off for positive.
module adc_seq #(
  parameter LCD = 1
) (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        clk_en,
  input  wire        zero_cross,
  input  wire        integ_sign,
  input  wire        hold_reading_input,
  input  wire        segment_check,
  output reg         short_to_mid,
  output reg         offset_loop,
  output reg         ref_charge,
  output reg         sense_connect,
  output reg         reference_deintegrate_phase,
  output reg         ref_pos,
  output reg         ref_neg,
  output reg         backplane_drive,
  output reg  [6:0]  seg_ones,
  output reg  [6:0]  seg_tens,
  output reg  [6:0]  seg_hund,
  output reg         seg_thou,
  output reg         seg_minus,
  output reg  [10:0] reading,
  output reg         overload,
  output reg         negative
);

  // ==========================================================
  // Input synchronisers (three stages, second and third agree)
  // ==========================================================
  reg [2:0] zc_s;
  reg [2:0] sg_s;
  reg [2:0] hd_s;
  reg [2:0] ck_s;
  reg       zc_q;
  reg       sg_q;
  reg       hd_q;
  reg       ck_q;

  // Filtered levels change only when the last two stages agree
  always @(posedge core_clk) begin
    if (reset) begin
      zc_s <= 3'h0;
      sg_s <= 3'h0;
      hd_s <= 3'h0;
      ck_s <= 3'h0;
      zc_q <= 1'b0;
      sg_q <= 1'b0;
      hd_q <= 1'b0; // Open hold input reads low
      ck_q <= 1'b0;
    end else if (clk_en) begin
      zc_s <= {zc_s[1:0], zero_cross};
      sg_s <= {sg_s[1:0], integ_sign};
      hd_s <= {hd_s[1:0], hold_reading_input};
      ck_s <= {ck_s[1:0], segment_check};
      if (zc_s[1] == zc_s[2]) zc_q <= zc_s[2];
      if (sg_s[1] == sg_s[2]) sg_q <= sg_s[2];
      if (hd_s[1] == hd_s[2]) hd_q <= hd_s[2];
      if (ck_s[1] == ck_s[2]) ck_q <= ck_s[2];
    end
  end

  // ==========================================================
  // Count clock prescaler
  // ==========================================================
  reg  [1:0] pre;
  wire       tick = (pre == `PRESCALE); // One count per four clocks

  always @(posedge core_clk) begin
    if (reset)
      pre <= 2'h0;
    else if (clk_en)
      pre <= pre + 2'h1;
  end

  // ==========================================================
  // Phase sequencer
  // ==========================================================
  localparam ST_NULL  = `PH_NULL;
  localparam ST_INTEG = `PH_INTEG;
  localparam ST_DEINT = `PH_DEINT;

  reg  [1:0]  phase;
  reg  [1:0]  next_phase;
  reg  [11:0] cyc_cnt;   // Counts within the whole 4000-count cycle
  reg  [11:0] ph_cnt;    // Counts within the current phase
  reg         sign_lat;  // High means negative input
  reg  [10:0] res_cnt;
  reg         res_ovl;
  reg         res_neg;
  reg         res_ready;

  wire deint_full = (ph_cnt == `FULL_SCALE - 12'h1);
  wire cycle_end  = (cyc_cnt == `CYCLE_COUNTS - 12'h1);

  // Next phase: null takes whatever deintegrate left unused
  always @* begin
    next_phase = phase;
    case (phase)
      ST_NULL:  if (cycle_end) next_phase = ST_INTEG;
      ST_INTEG: if (ph_cnt == `INTEG_COUNTS - 12'h1) next_phase = ST_DEINT;
      ST_DEINT: if (zc_q || deint_full) next_phase = ST_NULL;
      default:  next_phase = ST_NULL;
    endcase
  end

  // Phase registers, sign latch and result capture
  always @(posedge core_clk) begin
    if (reset) begin
      phase     <= ST_NULL;
      cyc_cnt   <= 12'h000;
      ph_cnt    <= 12'h000;
      sign_lat  <= 1'b0;
      res_cnt   <= 11'h000;
      res_ovl   <= 1'b0;
      res_neg   <= 1'b0;
      res_ready <= 1'b0;
    end else if (clk_en) begin
      res_ready <= 1'b0;
      if (tick) begin
        phase   <= next_phase;
        cyc_cnt <= (phase == ST_NULL && cycle_end) ? 12'h000 : cyc_cnt + 12'h001;
        ph_cnt  <= (next_phase != phase) ? 12'h000 : ph_cnt + 12'h001;
        if (phase == ST_INTEG && next_phase == ST_DEINT)
          sign_lat <= sg_q; // Sign sampled at end of integrate
        if (phase == ST_DEINT && next_phase == ST_NULL) begin
          res_cnt   <= zc_q ? ph_cnt[10:0] : 11'h7d0; // Count is the reading
          res_ovl   <= ~zc_q;                         // No crossing by full scale
          res_neg   <= sign_lat;
          res_ready <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Analog switch controls
  // ==========================================================
  always @(posedge core_clk) begin
    if (reset) begin
      short_to_mid                <= 1'b1;
      offset_loop                 <= 1'b1;
      ref_charge                  <= 1'b1;
      sense_connect               <= 1'b0;
      reference_deintegrate_phase <= 1'b0;
      ref_pos                     <= 1'b0;
      ref_neg                     <= 1'b0;
    end else if (clk_en) begin
      short_to_mid                <= (phase == ST_NULL);
      offset_loop                 <= (phase == ST_NULL);
      ref_charge                  <= (phase == ST_NULL);
      sense_connect               <= (phase == ST_INTEG);
      reference_deintegrate_phase <= (phase == ST_DEINT); // Low input tied to midpoint
      ref_pos                     <= (phase == ST_DEINT) && sign_lat;  // Opposite polarity
      ref_neg                     <= (phase == ST_DEINT) && !sign_lat;
    end
  end

  // ==========================================================
  // Display latches
  // ==========================================================
  // Conversions continue while held; only the latch load is gated
  always @(posedge core_clk) begin
    if (reset) begin
      reading  <= 11'h000;
      overload <= 1'b0;
      negative <= 1'b0;
    end else if (clk_en && res_ready && !hd_q) begin
      reading  <= res_cnt;
      overload <= res_ovl;
      negative <= res_neg;
    end
  end

  // ==========================================================
  // Decoding and segment drive
  // ==========================================================
  function [6:0] seg7;
    input [3:0] d;
    begin
      case (d)
        4'h0: seg7 = 7'h3f;
        4'h1: seg7 = 7'h06;
        4'h2: seg7 = 7'h5b;
        4'h3: seg7 = 7'h4f;
        4'h4: seg7 = 7'h66;
        4'h5: seg7 = 7'h6d;
        4'h6: seg7 = 7'h7d;
        4'h7: seg7 = 7'h07;
        4'h8: seg7 = 7'h7f;
        4'h9: seg7 = 7'h6f;
        default: seg7 = 7'h00;
      endcase
    end
  endfunction

  // Binary to decimal; divider is combinational but only settles on latch changes
  wire [10:0] r_thou = reading / 11'd1000;
  wire [10:0] r_rem  = reading - r_thou * 11'd1000;
  wire [10:0] r_hund = r_rem / 11'd100;
  wire [10:0] r_rem2 = r_rem - r_hund * 11'd100;
  wire [10:0] r_tens = r_rem2 / 11'd10;
  wire [10:0] r_ones = r_rem2 - r_tens * 11'd10;

  reg  [6:0] on_ones;
  reg  [6:0] on_tens;
  reg  [6:0] on_hund;
  reg        on_thou;
  reg        on_minus;

  // Segments that should be lit, before drive polarity
  always @* begin
    if (ck_q) begin
      on_ones  = 7'h7f; // Shows minus 1888
      on_tens  = 7'h7f;
      on_hund  = 7'h7f;
      on_thou  = 1'b1;
      on_minus = 1'b1;
    end else if (overload) begin
      on_ones  = 7'h00; // Low digits blanked
      on_tens  = 7'h00;
      on_hund  = 7'h00;
      on_thou  = 1'b1;
      on_minus = negative;
    end else begin
      on_ones  = seg7(r_ones[3:0]);
      on_tens  = seg7(r_tens[3:0]);
      on_hund  = seg7(r_hund[3:0]);
      on_thou  = (r_thou != 11'h000);
      on_minus = negative; // Lit for negative input
    end
  end

  // Backplane divider: toggle every 400 clocks
  reg [8:0] bp_cnt;

  always @(posedge core_clk) begin
    if (reset) begin
      bp_cnt          <= 9'h000;
      backplane_drive <= 1'b0;
    end else if (clk_en) begin
      if (LCD != 0) begin
        bp_cnt <= (bp_cnt == `BP_HALF) ? 9'h000 : bp_cnt + 9'h001;
        if (bp_cnt == `BP_HALF)
          backplane_drive <= ~backplane_drive; // Clock over 800
      end else
        backplane_drive <= 1'b0; // No backplane on LED build
    end
  end

  // Backplane level after this edge; registered segments must switch on the
  // same edge as the backplane, or each half period would leave a clock of DC
  wire bp_flip = (LCD != 0) && (bp_cnt == `BP_HALF);
  wire bp_next = bp_flip ? ~backplane_drive : backplane_drive;

  // Drive polarity: LCD xor with backplane, LED sinks active low
  wire pol = (LCD != 0) ? (ck_q ? 1'b1 : ~bp_next) : 1'b0;

  always @(posedge core_clk) begin
    if (reset) begin
      seg_ones  <= 7'h00;
      seg_tens  <= 7'h00;
      seg_hund  <= 7'h00;
      seg_thou  <= 1'b0;
      seg_minus <= 1'b0;
    end else if (clk_en) begin
      // LCD: in phase when off, inverted when on; held steady during
      // LED: low sinks current for a lit segment
      seg_ones  <= (LCD != 0) ? (on_ones ^ {7{~pol}})  : ~on_ones;
      seg_tens  <= (LCD != 0) ? (on_tens ^ {7{~pol}})  : ~on_tens;
      seg_hund  <= (LCD != 0) ? (on_hund ^ {7{~pol}})  : ~on_hund;
      seg_thou  <= (LCD != 0) ? (on_thou ^ ~pol)       : ~on_thou;
      seg_minus <= (LCD != 0) ? (on_minus ^ ~pol)      : ~on_minus;
    end
  end

endmodule // adc_seq
`default_nettype wire

// >>> verif/afe_model.sv
// ===========================================================
// Analog front-end model: comparator and sign for the sequencer.
// Assumes clk_en held high, so four clocks make one count.
`timescale 1ns/1ps
`default_nettype none
module afe_model (
  input  wire logic        core_clk,
  input  wire logic        reference_deintegrate_phase,
  input  wire logic [11:0] target,
  input  wire logic        neg_in,
  output logic             zero_cross,
  output logic             integ_sign
);
  logic [13:0] t;
  // Clocks spent ramping back; cleared outside deintegrate
  always @(posedge core_clk) begin
    if (!reference_deintegrate_phase)
      t <= 14'h0;
    else
      t <= t + 14'h1;
  end
  // Comparator trips one count early to offset the sequencer's input filter
  // latency, so a target just under full scale still reads without overload
  assign zero_cross = reference_deintegrate_phase && (t + 14'h4 >= {target, 2'b00});
  // Sign is a steady level, so the latch point does not matter
  assign integ_sign = neg_in;
endmodule // afe_model
`default_nettype wire

// >>> verif/adc_seq_monitor.sv
// ===========================================================
// Port checker for the converter sequencer, LCD build.
// Assumes clk_en held high throughout.
`timescale 1ns/1ps
`default_nettype none
module adc_seq_monitor (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       segment_check,
  input wire logic       short_to_mid,
  input wire logic       offset_loop,
  input wire logic       ref_charge,
  input wire logic       sense_connect,
  input wire logic       reference_deintegrate_phase,
  input wire logic       ref_pos,
  input wire logic       ref_neg,
  input wire logic       backplane_drive,
  input wire logic [6:0] seg_ones,
  input wire logic       seg_thou,
  input wire logic       seg_minus
);
  logic [14:0] cyc;
  logic [9:0]  bpc;
  logic        cyc_ok;
  logic        bp_ok;
  // Clocks since integrate start and since last backplane edge
  always @(posedge core_clk) begin
    if (reset) begin
      cyc <= 15'h0;
      bpc <= 10'h0;
      cyc_ok <= 1'b0;
      bp_ok <= 1'b0;
    end else begin
      cyc <= $rose(sense_connect) ? 15'h1 : cyc + 15'h1;
      bpc <= $changed(backplane_drive) ? 10'h1 : bpc + 10'h1;
      cyc_ok <= cyc_ok | $rose(sense_connect);
      bp_ok <= bp_ok | $changed(backplane_drive);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_NULL_CTRL: assert property (short_to_mid == offset_loop && offset_loop == ref_charge)
    else $error("null phase controls disagree");
  AST_ONE_PHASE: assert property ($onehot({short_to_mid, sense_connect, reference_deintegrate_phase}))
    else $error("not exactly one phase active");
  AST_ORDER: assert property ($fell(sense_connect) |-> reference_deintegrate_phase)
    else $error("integrate not followed by deintegrate");
  AST_INTEG_LEN: assert property ($fell(sense_connect) |-> cyc == 15'd4000)
    else $error("integrate length wrong");
  AST_DEINT_MAX: assert property ($fell(reference_deintegrate_phase) |-> cyc <= 15'd12000)
    else $error("deintegrate longer than full scale");
  AST_CYCLE: assert property ($rose(sense_connect) && cyc_ok |-> cyc == 15'd16000)
    else $error("cycle length wrong");
  AST_REF_POL: assert property (reference_deintegrate_phase |-> ref_pos != ref_neg)
    else $error("reference polarity not single");
  AST_BP: assert property ($changed(backplane_drive) && bp_ok |-> bpc == 10'd400)
    else $error("backplane half period wrong");
  AST_LAMP: assert property (segment_check [*8] |-> seg_ones == 7'h7f && seg_thou && seg_minus)
    else $error("lamp test not all on");
  AST_LAMP_DC: assert property (segment_check [*8] |=> $stable(seg_ones))
    else $error("lamp test segments toggle");
endmodule // adc_seq_monitor
`default_nettype wire

// >>> verif/adc_seq_tb.sv
// ===========================================================
// Self-checking bench for the converter sequencer, LCD build.
// Assumes the front-end model beside it; clk_en tied high.
`timescale 1ns/1ps
`default_nettype none
module adc_seq_tb;
  logic        core_clk, reset, hold, lamp, neg, zc, sgn;
  logic [11:0] tgt;
  wire         s_mid, s_loop, s_chg, s_con, s_de, r_pos, r_neg, bp, thou, minus, ovl, negf;
  wire  [6:0]  ones, tens, hund;
  wire  [10:0] rd;
  int          err_count, n_tests;
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  adc_seq #(.LCD(1)) u_adc_seq (.core_clk(core_clk), .reset(reset), .clk_en(1'b1), .zero_cross(zc),
    .integ_sign(sgn), .hold_reading_input(hold), .segment_check(lamp), .short_to_mid(s_mid),
    .offset_loop(s_loop), .ref_charge(s_chg), .sense_connect(s_con), .reference_deintegrate_phase(s_de),
    .ref_pos(r_pos), .ref_neg(r_neg), .backplane_drive(bp), .seg_ones(ones), .seg_tens(tens),
    .seg_hund(hund), .seg_thou(thou), .seg_minus(minus), .reading(rd), .overload(ovl), .negative(negf));
  afe_model u_afe_model (.core_clk(core_clk), .reference_deintegrate_phase(s_de), .target(tgt),
    .neg_in(neg), .zero_cross(zc), .integ_sign(sgn));
  task give_verdict;
    begin
      $display("Checks: %0d, errors: %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // Exact compare of a flag or segment field
  task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    begin
      n_tests++;
      if (g !== e) begin
        err_count++;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Reading may land one count late through the input filter
  task chk_rd(input logic [11:0] e);
    begin
      n_tests++;
      if ({1'b0, rd} !== e && {1'b0, rd} !== e + 12'h1) begin
        err_count++;
        $display("[ERR] reading expected %0d seen %0d", e, rd);
      end
    end
  endtask
  // Next integrate start, bounded by one cycle plus margin
  task wait_rise;
    int   i;
    logic p;
    begin
      p = 1'b1;
      for (i = 0; i < 17000 && !(s_con === 1'b1 && !p); i++) begin
        p = s_con;
        @(negedge core_clk);
      end
      if (i == 17000) begin
        err_count++;
        $display("[ERR] integrate start expected 1 seen 0");
        give_verdict;
      end
    end
  endtask
  task s_read(input logic [11:0] t, input logic n);
    begin
      tgt = t;
      neg = n;
      wait_rise;
      chk_rd(t);
      chk("negative", {11'h0, n}, {11'h0, negf});
      chk("overload", 12'h0, {11'h0, ovl});
    end
  endtask
  task s_over;
    int   i;
    logic p;
    begin
      tgt = 12'd2047;
      wait_rise;
      chk_rd(12'd2000);
      chk("overload", 12'h1, {11'h0, ovl});
      p = bp;
      for (i = 0; i < 900 && bp === p; i++)
        @(negedge core_clk);
      if (i == 900) begin
        err_count++;
        $display("[ERR] backplane edge expected 1 seen 0");
        give_verdict;
      end
      repeat (8) @(negedge core_clk);
      chk("ones", {5'h0, {7{bp}}}, {5'h0, ones});
      chk("hund", {5'h0, {7{bp}}}, {5'h0, hund});
      chk("thou", {11'h0, ~bp}, {11'h0, thou});
    end
  endtask
  task s_lamp;
    begin
      lamp = 1'b1;
      repeat (20) @(negedge core_clk);
      chk("ones", 12'h07f, {5'h0, ones});
      chk("minus", 12'h1, {11'h0, minus});
      repeat (420) @(negedge core_clk);
      chk("tens", 12'h07f, {5'h0, tens});
      lamp = 1'b0;
    end
  endtask
  task s_hold;
    begin
      hold = 1'b1;
      tgt = 12'd300;
      wait_rise;
      chk_rd(12'd2000);
      chk("overload", 12'h1, {11'h0, ovl});
      hold = 1'b0;
    end
  endtask
  initial begin
    reset = 1'b1;
    hold = 1'b0;
    lamp = 1'b0;
    neg = 1'b0;
    tgt = 12'd500;
    err_count = 0;
    n_tests = 0;
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    wait_rise;
    s_read(12'd500, 1'b0);
    s_over;
    s_lamp;
    s_hold;
    s_read(12'd1999, 1'b1);
    give_verdict;
  end
endmodule // adc_seq_tb
bind adc_seq adc_seq_monitor u_adc_seq_monitor (.core_clk(core_clk), .reset(reset),
  .segment_check(segment_check), .short_to_mid(short_to_mid), .offset_loop(offset_loop),
  .ref_charge(ref_charge), .sense_connect(sense_connect),
  .reference_deintegrate_phase(reference_deintegrate_phase), .ref_pos(ref_pos), .ref_neg(ref_neg),
  .backplane_drive(backplane_drive), .seg_ones(seg_ones), .seg_thou(seg_thou), .seg_minus(seg_minus));
`default_nettype wire
